// [src/port_pins_with_change_irq.sv]
// GPIO port pair with pin-change and external interrupt flags
`timescale 1ns/1ps
`include "port_pins_map.svh"
module port_pins_with_change_irq import port_pins_pkg::*; (
  input  wire logic        clk_sys_i,        // System clock, 100 MHz
  input  wire logic        sys_rst_i,        // Reset, active high; synchronous except at the pin drivers
  input  wire logic [7:0]  avs_address_i,    // Byte address
  input  wire logic        avs_read_i,       // Read request
  input  wire logic        avs_write_i,      // Write request
  input  wire logic [31:0] avs_writedata_i,  // Write data
  input  wire logic [3:0]  avs_byteenable_i, // Byte enables
  output logic      [31:0] avs_readdata_o,   // Read data
  output logic             avs_waitrequest_o,// Wait request
  input  wire logic        global_irq_en_i,  // CPU status global enable
  input  wire logic [2:0]  vector_entry_i,   // Routine entered: 0 ext, 1 grp0, 2 grp1
  input  wire logic [11:0] pad_in_i,         // Pin levels
  output logic      [11:0] pad_out_o,        // Pin drive value
  output logic      [11:0] pad_oe_o,         // Pin drive enable
  output logic      [11:0] pullup_en_o,      // Pull-up enables
  output logic             ext_irq_req_o,    // External vector request
  output logic             chg0_irq_req_o,   // Group-0 vector request
  output logic             chg1_irq_req_o    // Group-1 vector request
);

  // Bus state and answer
  bus_state_t  bus_state_r, bus_state_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // Port registers; in out_r and dir_r bit n is pin n across both ports
  logic [11:0] out_r, out_nxt;                // Output value bits
  logic [11:0] dir_r, dir_nxt;                // Direction bits
  logic [7:0]  low_mask_r, low_mask_nxt;      // Lower change mask
  logic [3:0]  high_mask_r, high_mask_nxt;    // Upper change mask
  logic [7:0]  flags_r, flags_nxt;            // Interrupt flags
  logic [7:0]  gen_mask_r, gen_mask_nxt;      // General interrupt mask
  logic [7:0]  mcu_ctrl_r, mcu_ctrl_nxt;      // Sense and pull-up control
  // Pin synchronisers and change history
  // Pads are asynchronous to the system clock, so nothing but the
  // second stage may look at the first one.
  logic [11:0] pin_meta_r;                    // First stage, read by second only
  logic [11:0] pin_sync_r;                    // Second stage
  logic [11:0] pin_prev_r;                    // Previous synced value
  // Registered outputs
  logic [11:0] pad_out_r, pad_oe_r, pullup_r;
  logic        ext_req_r, chg0_req_r, chg1_req_r;
  logic        ext_req_nxt, chg0_req_nxt, chg1_req_nxt;

  // Decode helpers
  logic [5:0]  idx;
  logic        wr_go, rd_go;
  logic [7:0]  wd;
  logic [11:0] pin_diff;
  logic        ext_level, ext_event, grp0_event, grp1_event;
  sense_t      sense;
  bit_op_t     bop_tgt;
  logic [3:0]  bop_pin;
  logic [11:0] bop_sel;

  // Registers sit on word steps; address bits 1..0 are ignored.
  // Only byte lane 0 carries register data. The upper lanes are
  // dropped on write and read back as zero.
  // A write with lane 0 disabled changes nothing at all.
  assign idx   = avs_address_i[7:2];
  assign wd    = avs_writedata_i[7:0];
  assign wr_go = (bus_state_r == BUS_ACK) && avs_write_i && avs_byteenable_i[0];
  assign rd_go = (bus_state_r == BUS_IDLE) && avs_read_i;
  assign sense = sense_t'({mcu_ctrl_r[`BIT_SENSE_HI], mcu_ctrl_r[`BIT_SENSE_LO]});
  assign bop_tgt = bit_op_t'(wd[5:4]);
  assign bop_pin = wd[3:0];
  assign bop_sel = 12'h001 << bop_pin;

  // Change is synced value versus one clock earlier
  assign pin_diff   = pin_sync_r ^ pin_prev_r;
  assign ext_level  = pin_sync_r[`EXT_PIN];
  // Sense code comes from the control register; a new code
  // takes effect on the clock after the write lands.
  // The pin is sampled before edges are looked for, so a glitch
  // between two edges is simply not seen.
  // Edge detection needs pulses longer than one clock to be seen
  always_comb begin
    unique case (sense)
      SENSE_LOW:  ext_event = 1'b0;
      SENSE_ANY:  ext_event = pin_diff[`EXT_PIN];
      SENSE_FALL: ext_event = pin_diff[`EXT_PIN] && !ext_level;
      SENSE_RISE: ext_event = pin_diff[`EXT_PIN] && ext_level;
    endcase
  end
  // Masked group change, gated by the group enable
  assign grp0_event = gen_mask_r[`BIT_GRP0] && |(pin_diff[7:0] & low_mask_r);
  assign grp1_event = gen_mask_r[`BIT_GRP1] && |(pin_diff[11:8] & high_mask_r);

  // Bus handshake: one wait cycle, then the answer
  // Every access takes two cycles. Read data is latched at the end
  // of the wait cycle, so it stands while waitrequest is low.
  // A write commits only in the answer cycle, so it lands once
  // even though the master holds the request for two cycles.
  // Back-to-back requests simply start another two-cycle round.
  always_comb begin
    bus_state_nxt = bus_state_r;
    rdata_nxt     = rdata_r;
    if (bus_state_r == BUS_IDLE) begin
      // Request seen, answer next cycle
      if (avs_read_i || avs_write_i) begin
        bus_state_nxt = BUS_ACK;
      end
    end else begin
      // Transfer completes at this edge
      bus_state_nxt = BUS_IDLE;
    end
    if (rd_go) begin
      // Unmapped and reserved bits read zero
      rdata_nxt = 32'h0000_0000;
      unique case (idx)
        `IDX_OUT_A:     rdata_nxt[7:0] = out_r[7:0];
        `IDX_DIR_A:     rdata_nxt[7:0] = dir_r[7:0];
        `IDX_PIN_A:     rdata_nxt[7:0] = pin_sync_r[7:0];
        `IDX_OUT_B:     rdata_nxt[3:0] = out_r[11:8];
        `IDX_DIR_B:     rdata_nxt[3:0] = dir_r[11:8];
        `IDX_PIN_B:     rdata_nxt[3:0] = pin_sync_r[11:8];
        `IDX_LOW_MASK:  rdata_nxt[7:0] = low_mask_r;
        `IDX_FLAGS:     rdata_nxt[7:0] = flags_r & `FLAGS_IMPL;
        `IDX_HIGH_MASK: rdata_nxt[7:0] = {4'h0, high_mask_r};
        `IDX_GEN_MASK:  rdata_nxt[7:0] = gen_mask_r;
        `IDX_MCU_CTRL:  rdata_nxt[7:0] = mcu_ctrl_r;
        default:        rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Register file next values
  // Port A holds pins 7..0, port B pins 11..8 in its low nibble.
  // The pin input location is read-only; a write there toggles
  // the output value bits instead of storing anything.
  // Bit operations give software a read-modify-write free way to
  // change one pin without racing another writer.
  always_comb begin
    out_nxt       = out_r;
    dir_nxt       = dir_r;
    low_mask_nxt  = low_mask_r;
    high_mask_nxt = high_mask_r;
    gen_mask_nxt  = gen_mask_r;
    mcu_ctrl_nxt  = mcu_ctrl_r;
    flags_nxt     = flags_r;
    if (wr_go) begin
      unique case (idx)
        `IDX_OUT_A:     out_nxt[7:0]  = wd;
        `IDX_DIR_A:     dir_nxt[7:0]  = wd;
        `IDX_PIN_A:     out_nxt[7:0]  = out_r[7:0] ^ wd;
        `IDX_OUT_B:     out_nxt[11:8] = wd[3:0];
        `IDX_DIR_B:     dir_nxt[11:8] = wd[3:0];
        `IDX_PIN_B:     out_nxt[11:8] = out_r[11:8] ^ wd[3:0];
        `IDX_BIT_OP: begin
          // One pin only; all others keep their bits
          if (bop_pin < 4'hc) begin
            if (bop_tgt == BOP_OUT) begin
              out_nxt = wd[`BOP_VAL_BIT] ? (out_r | bop_sel) : (out_r & ~bop_sel);
            end else if (bop_tgt == BOP_DIR) begin
              dir_nxt = wd[`BOP_VAL_BIT] ? (dir_r | bop_sel) : (dir_r & ~bop_sel);
            end
          end
        end
        `IDX_LOW_MASK:  low_mask_nxt  = wd;
        `IDX_HIGH_MASK: high_mask_nxt = wd[3:0];
        `IDX_GEN_MASK:  gen_mask_nxt  = wd & `GEN_MASK_IMPL;
        `IDX_MCU_CTRL:  mcu_ctrl_nxt  = wd & `MCU_CTRL_IMPL;
        default: ;
      endcase
    end
    // Clear by write-one or routine entry; a new event wins
    if (wr_go && idx == `IDX_FLAGS) begin
      flags_nxt = flags_nxt & ~(wd & `FLAGS_IMPL);
    end
    if (vector_entry_i[0]) flags_nxt[`BIT_EXT]  = 1'b0;
    if (vector_entry_i[1]) flags_nxt[`BIT_GRP0] = 1'b0;
    if (vector_entry_i[2]) flags_nxt[`BIT_GRP1] = 1'b0;
    if (ext_event)  flags_nxt[`BIT_EXT]  = 1'b1;
    if (grp0_event) flags_nxt[`BIT_GRP0] = 1'b1;
    if (grp1_event) flags_nxt[`BIT_GRP1] = 1'b1;
    // Level sensing never holds the flag
    if (sense == SENSE_LOW) flags_nxt[`BIT_EXT] = 1'b0;
    flags_nxt = flags_nxt & `FLAGS_IMPL;
  end

  // Vector requests; level mode requests while pin stays low
  // Requests are levels: they drop one clock after the flag is
  // cleared or an enable goes away. Level mode has no flag, so
  // the request follows the synced pin directly.
  always_comb begin
    ext_req_nxt  = global_irq_en_i && gen_mask_r[`BIT_EXT] &&
                   (flags_r[`BIT_EXT] || (sense == SENSE_LOW && !ext_level));
    chg0_req_nxt = global_irq_en_i && gen_mask_r[`BIT_GRP0] && flags_r[`BIT_GRP0];
    chg1_req_nxt = global_irq_en_i && gen_mask_r[`BIT_GRP1] && flags_r[`BIT_GRP1];
  end

  // Control and bus registers
  // Synchronous reset; the synchroniser also restarts from zero,
  // which is harmless because every mask is cleared as well.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      bus_state_r <= BUS_IDLE;
      rdata_r     <= 32'h0000_0000;
      out_r       <= 12'h000;
      dir_r       <= 12'h000;
      low_mask_r  <= `REG_RESET;
      high_mask_r <= 4'h0;
      flags_r     <= `REG_RESET;
      gen_mask_r  <= `REG_RESET;
      mcu_ctrl_r  <= `REG_RESET;
      ext_req_r   <= 1'b0;
      chg0_req_r  <= 1'b0;
      chg1_req_r  <= 1'b0;
      pin_meta_r  <= 12'h000;
      pin_sync_r  <= 12'h000;
      pin_prev_r  <= 12'h000;
    end else begin
      bus_state_r <= bus_state_nxt;
      rdata_r     <= rdata_nxt;
      out_r       <= out_nxt;
      dir_r       <= dir_nxt;
      low_mask_r  <= low_mask_nxt;
      high_mask_r <= high_mask_nxt;
      flags_r     <= flags_nxt;
      gen_mask_r  <= gen_mask_nxt;
      mcu_ctrl_r  <= mcu_ctrl_nxt;
      ext_req_r   <= ext_req_nxt;
      chg0_req_r  <= chg0_req_nxt;
      chg1_req_r  <= chg1_req_nxt;
      pin_meta_r  <= pad_in_i;
      pin_sync_r  <= pin_meta_r;
      pin_prev_r  <= pin_sync_r;
    end
  end

  // Pin drivers: reset reaches them even with the clock stopped
  // These flops take the next values, so pins follow a write at
  // the same edge that updates the registers.
  // The asynchronous reset costs a second reset style in this
  // block, traded for pins that float without any clock.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pad_oe_r  <= 12'h000;
      pad_out_r <= 12'h000;
      pullup_r  <= 12'h000;
    end else begin
      pad_oe_r  <= dir_nxt;
      pad_out_r <= out_nxt & dir_nxt;
      // Pull-up only on inputs, and never while globally disabled
      pullup_r  <= out_nxt & ~dir_nxt & {12{~mcu_ctrl_nxt[`BIT_PUD]}};
    end
  end

  // Every output comes from a flop; waitrequest through a decode of the bus state flop
  // Waitrequest is high whenever no answer is due
  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = (bus_state_r == BUS_IDLE);
  assign pad_oe_o          = pad_oe_r;
  assign pad_out_o         = pad_out_r;
  assign pullup_en_o       = pullup_r;
  assign ext_irq_req_o     = ext_req_r;
  assign chg0_irq_req_o    = chg0_req_r;
  assign chg1_irq_req_o    = chg1_req_r;

  // Checks on the block's own behaviour
  // All of them run on the system clock; all but AST_RESET_TRI are off in reset.
  // Sampled-value functions see reset values on the first clock
  // after release, which every antecedent below tolerates.
  // The external pin also belongs to the upper change group.
  AST_EXT_SET: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ext_event && sense != SENSE_LOW |=> flags_r[`BIT_EXT])
    else $error("external flag not set after request");
  AST_EXT_DISPATCH: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ext_irq_req_o |-> $past(global_irq_en_i) && $past(gen_mask_r[`BIT_EXT]))
    else $error("external request without enables");
  AST_ENTRY_CLR: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    vector_entry_i[1] && !grp0_event |=> !flags_r[`BIT_GRP0])
    else $error("group-0 flag survived routine entry");
  AST_LEVEL_CLR: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sense == SENSE_LOW |=> !flags_r[`BIT_EXT])
    else $error("external flag set in level mode");
  AST_GRP1_SET: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    gen_mask_r[`BIT_GRP1] && |(pin_diff[11:8] & high_mask_r) |=> flags_r[`BIT_GRP1])
    else $error("group-1 flag missed a change");
  AST_GRP0_SET: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $changed(pin_sync_r[0]) && low_mask_r[0] && gen_mask_r[`BIT_GRP0] |=> flags_r[`BIT_GRP0])
    else $error("group-0 flag missed a change");
  AST_RSV_ZERO: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    rd_go && idx == `IDX_FLAGS |=> avs_readdata_o[7] == 1'b0 && avs_readdata_o[3:0] == 4'h0)
    else $error("reserved flag bits not zero");
  AST_TOGGLE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_go && idx == `IDX_PIN_A |=> out_r[7:0] == ($past(out_r[7:0]) ^ $past(wd)))
    else $error("pin write did not toggle output");
  AST_PULLUP: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    mcu_ctrl_r[`BIT_PUD] |-> pullup_en_o == 12'h000)
    else $error("pull-up on while globally disabled");
  AST_DRIVE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ##1 (pad_oe_o == dir_r) && ((pad_out_o & pad_oe_o) == (out_r & dir_r)))
    else $error("pin drive does not follow registers");
  AST_RESET_TRI: assert property (@(posedge clk_sys_i)
    sys_rst_i |=> pad_oe_o == 12'h000)
    else $error("pins driven after reset");

  // Group-0 request only with all three conditions
  AST_GRP0_DISPATCH: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    chg0_irq_req_o |-> $past(global_irq_en_i) && $past(gen_mask_r[`BIT_GRP0]) && $past(flags_r[`BIT_GRP0]))
    else $error("group-0 request without enables");

  // Group-1 request only with all three conditions
  AST_GRP1_DISPATCH: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    chg1_irq_req_o |-> $past(global_irq_en_i) && $past(gen_mask_r[`BIT_GRP1]) && $past(flags_r[`BIT_GRP1]))
    else $error("group-1 request without enables");

  // A set external flag with enables must request
  AST_EXT_REQ: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    flags_r[`BIT_EXT] && gen_mask_r[`BIT_EXT] && global_irq_en_i |=> ext_irq_req_o)
    else $error("external request missing");

  // Group-1 flag rises only from a masked change
  AST_GRP1_ONLY: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(flags_r[`BIT_GRP1]) |-> $past(grp1_event))
    else $error("group-1 flag set by a masked pin");

  // Group-0 flag rises only from a masked change
  AST_GRP0_ONLY: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(flags_r[`BIT_GRP0]) |-> $past(grp0_event))
    else $error("group-0 flag set by a masked pin");

  // Pin input location shows the synced pins
  AST_PIN_VIEW: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    rd_go && idx == `IDX_PIN_A |=> avs_readdata_o == {24'h00_0000, $past(pin_sync_r[7:0])})
    else $error("pin input read wrong");

  // Direction write drives the enables next clock
  AST_DIR_OE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_go && idx == `IDX_DIR_A |=> pad_oe_o[7:0] == $past(wd))
    else $error("direction write not on the pins");

  // No pull-up on an output pin
  AST_PULL_INPUT: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (pullup_en_o & dir_r) == 12'h000)
    else $error("pull-up on an output pin");

  // Bit operation on direction touches one bit only
  AST_BIT_OP_ONE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_go && idx == `IDX_BIT_OP && bop_tgt == BOP_DIR |=> ((dir_r ^ $past(dir_r)) & ~$past(bop_sel)) == 12'h000)
    else $error("bit operation changed another pin");

  // Falling mode ignores a rising edge
  AST_FALL_ONLY: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sense == SENSE_FALL && ext_level && !flags_r[`BIT_EXT] |=> !flags_r[`BIT_EXT])
    else $error("rising edge set flag in falling mode");

  // Reserved upper mask bits read zero
  AST_RSV_HIGH: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    rd_go && idx == `IDX_HIGH_MASK |=> avs_readdata_o[7:4] == 4'h0)
    else $error("reserved mask bits not zero");

endmodule : port_pins_with_change_irq

// [src/port_pins_map.svh]
// Register indices, field positions and reset values of the port block
`ifndef PORT_PINS_MAP_SVH
`define PORT_PINS_MAP_SVH
// Register indices; byte address is four times the index
`define IDX_OUT_A      6'h00
`define IDX_DIR_A      6'h01
`define IDX_PIN_A      6'h02
`define IDX_OUT_B      6'h03
`define IDX_DIR_B      6'h04
`define IDX_PIN_B      6'h05
`define IDX_BIT_OP     6'h06
`define IDX_LOW_MASK   6'h12
`define IDX_FLAGS      6'h13
`define IDX_HIGH_MASK  6'h14
`define IDX_GEN_MASK   6'h15
`define IDX_MCU_CTRL   6'h16
// Flag and enable bit positions (shared by flags and general mask)
`define BIT_EXT        6
`define BIT_GRP1       5
`define BIT_GRP0       4
// Control register fields
`define BIT_PUD        6
`define BIT_SENSE_HI   1
`define BIT_SENSE_LO   0
// Implemented bits of the flag, upper mask, general mask and control registers
`define FLAGS_IMPL     8'h70
`define HIGH_MASK_IMPL 8'h0f
`define GEN_MASK_IMPL  8'h70
`define MCU_CTRL_IMPL  8'h43
// Reset value of every register
`define REG_RESET      8'h00
// Pin that serves as the external interrupt input
`define EXT_PIN        10
// Bit-operation register fields
`define BOP_VAL_BIT    6
`endif

// [src/port_pins_pkg.sv]
// Types for the port pin block
package port_pins_pkg;
  // Bus handshake state
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;
  // External interrupt sense selection
  typedef enum logic [1:0] {
    SENSE_LOW    = 2'b00,
    SENSE_ANY    = 2'b01,
    SENSE_FALL   = 2'b10,
    SENSE_RISE   = 2'b11
  } sense_t;
  // Target of a single-bit operation
  typedef enum logic [1:0] {
    BOP_OUT  = 2'b00,
    BOP_DIR  = 2'b01,
    BOP_NONE = 2'b10,
    BOP_RSV  = 2'b11
  } bit_op_t;
endpackage : port_pins_pkg

// [verif/pad_partner.sv]
// Model of the external signals that sit on the port pins
`timescale 1ns/1ps
module pad_partner (
  input  wire logic        clk_sys_i,   // System clock
  input  wire logic [11:0] pad_out_i,   // Block drive value
  input  wire logic [11:0] pad_oe_i,    // Block drive enable
  input  wire logic [11:0] pullup_en_i, // Block pull-up enable
  input  wire logic [11:0] ext_val_i,   // Level forced by the far side
  input  wire logic [11:0] ext_en_i,    // Far side drives this pin
  output logic      [11:0] pad_level_o  // Resolved pin level
);
  logic [11:0] last_r; // Last resolved level
  // Undriven pins with no pull-up flip each cycle so X never hides as 0
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (pad_oe_i[i]) pad_level_o[i] = pad_out_i[i];
      else if (ext_en_i[i]) pad_level_o[i] = ext_val_i[i];
      else if (pullup_en_i[i]) pad_level_o[i] = 1'b1;
      else pad_level_o[i] = ~last_r[i];
    end
  end
  // Remember level for the floating case
  always_ff @(posedge clk_sys_i) begin
    last_r <= pad_level_o;
  end
endmodule : pad_partner

// [verif/tb_top.sv]
// Self-checking bench for the port pin block
`timescale 1ns/1ps
`include "port_pins_map.svh"
module tb_top;
  logic        clk_sys_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, global_irq_en_i;
  logic        ext_irq_req_o, chg0_irq_req_o, chg1_irq_req_o;
  logic [7:0]  avs_address_i, r, d, e;
  logic [31:0] avs_writedata_i, avs_readdata_o, seed;
  logic [3:0]  avs_byteenable_i;
  logic [2:0]  vector_entry_i;
  logic [11:0] pad_in_i, pad_out_o, pad_oe_o, pullup_en_o, ext_val, ext_en;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  int          mismatches, cmp_count;

  port_pins_with_change_irq i_port_pins_with_change_irq (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .global_irq_en_i(global_irq_en_i), .vector_entry_i(vector_entry_i),
    .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pullup_en_o(pullup_en_o),
    .ext_irq_req_o(ext_irq_req_o), .chg0_irq_req_o(chg0_irq_req_o), .chg1_irq_req_o(chg1_irq_req_o));
  pad_partner i_pad_partner (.clk_sys_i(clk_sys_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .pullup_en_i(pullup_en_o), .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_level_o(pad_in_i));

  // Clock, 100 MHz
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Print counts and verdict, then stop
  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  // Compare one pin-side value
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] dat);
    int n;
    @(posedge clk_sys_i);
    avs_address_i <= {idx, 2'b00};
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_writedata_i <= {24'h0, dat};
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    if (avs_waitrequest_o !== 1'b0) mismatches++;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] idx, input logic [7:0] dat);
    bus(1'b1, idx, dat);
  endtask : wr
  // Read; the note goes to the queue first
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, idx, 8'h00);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : wt
  // Toggle far-side pins; held for many cycles, never a short pulse
  task automatic flip(input logic [11:0] m);
    @(posedge clk_sys_i);
    ext_val <= ext_val ^ m;
    wt(6);
  endtask : flip

  // Monitor: read answer taken at the edge where waitrequest is low
  always @(posedge clk_sys_i) begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
      cmp_count++;
      if (exp_q.size() == 0 || avs_readdata_o !== exp_q[0]) begin
        mismatches++;
        $display("MISMATCH at %0t: got %h expected %h", $time, avs_readdata_o, exp_q[0]);
      end
      if (exp_q.size() != 0) exp_q.pop_front();
    end
  end
  // Watchdog, far beyond the expected run
  initial begin
    #50000;
    mismatches++;
    conclude();
  end

  initial begin
    {avs_read_i, avs_write_i, vector_entry_i, avs_address_i, avs_writedata_i} = '0;
    sys_rst_i = 1'b1;
    avs_byteenable_i = 4'hf;
    global_irq_en_i = 1'b1;
    ext_en = 12'hfff;
    ext_val = 12'h000;
    seed = 32'hc5c1bb8f;
    wt(20);
    sys_rst_i <= 1'b0;
    rd(`IDX_LOW_MASK, 32'h0);
    rd(`IDX_FLAGS, 32'h0);
    rd(`IDX_OUT_A, 32'h0);
    rd(6'h30, 32'h0);
    $display("test reset_values done");
    seed = lfsr(seed);
    r = seed[7:0];
    d = seed[15:8] | 8'h01;
    e = seed[23:16];
    ext_val <= {4'h0, e};
    wr(`IDX_OUT_A, r);
    wr(`IDX_DIR_A, d);
    wt(3);
    chk(pad_oe_o, {4'h0, d});
    chk(pad_out_o, {4'h0, r & d});
    chk(pullup_en_o, {4'h0, r & ~d});
    rd(`IDX_PIN_A, {24'h0, (r & d) | (e & ~d)});
    wr(`IDX_MCU_CTRL, 8'h40);
    wt(3);
    chk(pullup_en_o, 12'h000);
    wr(`IDX_MCU_CTRL, 8'h00);
    wr(`IDX_PIN_A, e);
    rd(`IDX_OUT_A, {24'h0, r ^ e});
    wr(`IDX_BIT_OP, 8'h59);
    rd(`IDX_DIR_B, 32'h2);
    rd(`IDX_DIR_A, {24'h0, d});
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    #1;
    chk(pad_oe_o, 12'h000);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    $display("test port_config done");
    wr(`IDX_LOW_MASK, 8'h01);
    wr(`IDX_GEN_MASK, 8'h70);
    flip(12'h002);
    rd(`IDX_FLAGS, 32'h0);
    flip(12'h001);
    rd(`IDX_FLAGS, 32'h10);
    chk({11'h0, chg0_irq_req_o}, 12'h001);
    global_irq_en_i <= 1'b0;
    wt(2);
    chk({11'h0, chg0_irq_req_o}, 12'h000);
    global_irq_en_i <= 1'b1;
    wr(`IDX_FLAGS, 8'h10);
    rd(`IDX_FLAGS, 32'h0);
    flip(12'h001);
    @(posedge clk_sys_i);
    vector_entry_i <= 3'b010;
    @(posedge clk_sys_i);
    vector_entry_i <= 3'b000;
    rd(`IDX_FLAGS, 32'h0);
    wr(`IDX_HIGH_MASK, 8'hff);
    rd(`IDX_HIGH_MASK, 32'h0f);
    wr(`IDX_HIGH_MASK, 8'h02);
    flip(12'h100);
    rd(`IDX_FLAGS, 32'h0);
    flip(12'h200);
    rd(`IDX_FLAGS, 32'h20);
    chk({11'h0, chg1_irq_req_o}, 12'h001);
    @(posedge clk_sys_i);
    vector_entry_i <= 3'b100;
    @(posedge clk_sys_i);
    vector_entry_i <= 3'b000;
    rd(`IDX_FLAGS, 32'h0);
    $display("test pin_change done");
    for (int s = 0; s < 4; s++) begin
      wr(`IDX_MCU_CTRL, 8'(s));
      if (ext_val[10]) flip(12'h400);
      wr(`IDX_FLAGS, 8'h40);
      if (s == 0) chk({11'h0, ext_irq_req_o}, 12'h001);
      flip(12'h400);
      rd(`IDX_FLAGS, (s == 1 || s == 3) ? 32'h40 : 32'h0);
      if (s == 3) chk({11'h0, ext_irq_req_o}, 12'h001);
      wr(`IDX_FLAGS, 8'h40);
      flip(12'h400);
      rd(`IDX_FLAGS, (s == 1 || s == 2) ? 32'h40 : 32'h0);
    end
    $display("test ext_sense done");
    wt(4);
    conclude();
  end
endmodule : tb_top
